// ### verilog/smw_pkg.sv
// Package for the serial multiplexed word port: constants and carriers
package smw_pkg;
  localparam int SMW_ADDR_W = 7;
  localparam int SMW_WORD_W = 32;
  localparam logic [6:0] SMW_ADDR_MAX = 7'h7c;
  localparam int SMW_RO_BIT = 0;
  localparam int SMW_WO_BIT = 1;
  localparam int SMW_BYTES_PER_WORD = 4;
  localparam int SMW_SYS_CLK_HZ = 10_000_000;
  localparam int SMW_XFER_TIME_US = 64;
  localparam int SMW_XFER_CYCLES = SMW_XFER_TIME_US * (SMW_SYS_CLK_HZ / 1_000_000);
  localparam int SMW_CLK_DIV = 4;
  localparam logic [31:0] SMW_WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [31:0] wdata;
  } smw_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic blocked;
  } smw_rsp_s;

  typedef enum logic [1:0] {
    SMW_IDLE = 2'b00,
    SMW_WAIT = 2'b01,
    SMW_DONE = 2'b11
  } smw_state_e;

  typedef enum logic [1:0] {
    SMW_L_IDLE = 2'b00,
    SMW_L_SHIFT = 2'b01,
    SMW_L_ACK = 2'b11
  } smw_lstate_e;
endpackage

// ### verilog/smw_word_port.sv
// Serial multiplexed 32-bit word port: request side and link shifter
`timescale 1ns/1ns
// ==============================================================
// Notes on behaviour
// - A word address is a multiple of four from 0 to 124 naming the first of four bytes of a 32-bit word.
// - Address bit 0 marks a word read-only, address bit 1 marks it write-only.
// - Only whole 32-bit words move; no single bit is addressed alone.
// - A word is wholly input or wholly output, never mixed.
// - After reset every word is an input and all outputs are off, pulled high.
// - A write makes the whole word an output driving each bit from the written value.
// - A read of an output word turns it back to input with all outputs off.
// - With both low address bits clear, both reads and writes are allowed.
// - A write to an address with bit 0 set is blocked and nothing moves on the port.
// - A read from an address with bit 1 set returns zero with no transfer on the port.
// - A whole word transfer lasts about 64 microseconds.
// - Transfers are issued only from background task slots, never foreground ones.
module smw_word_port
  import smw_pkg::*;
#(
  parameter int XFER_CYCLES = SMW_XFER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic req_valid,
  input wire logic req_background,
  input wire smw_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output smw_rsp_s rsp,
  output logic [31:0] dir_out_reg,
  output logic port_clk,
  output logic port_sel,
  output logic [6:0] port_byte_addr,
  output logic port_dout,
  output logic port_write,
  input wire logic port_din
);

  // ==============================================================
  // Declarations
  smw_state_e state_reg;
  smw_state_e state_next;
  logic [15:0] wait_cnt_reg;
  logic go_tog_reg;
  logic job_write_reg;
  logic [4:0] job_word_reg;
  logic [31:0] job_data_reg;
  logic [2:0] done_sync_reg;
  logic [31:0] rd_hold_reg;
  logic done_seen;
  logic take;
  logic blocked_now;
  logic accept;
  logic span_done;
  logic finish;
  smw_lstate_e lstate_reg;
  logic [2:0] go_sync_reg;
  logic go_seen;
  logic done_tog_reg;
  logic [31:0] lk_shift_reg;
  logic [5:0] bit_cnt_reg;
  logic [1:0] div_reg;
  logic [1:0] din_sync_reg;
  logic ph_low;
  logic ph_high;
  logic ph_sample;
  logic last_bit;
  logic frame_start;

  // ==============================================================
  // Decoding
  // Word index of a byte address; the two low bits only gate access
  function automatic logic [4:0] word_of(input logic [6:0] addr);
    word_of = addr[6:2];
  endfunction

  // Shared by the answer path and the direction map
  function automatic logic refused(input logic wr, input logic [6:0] addr, input logic bg);
    logic in_range;
    in_range = ({addr[6:2], 2'b00} <= SMW_ADDR_MAX);
    refused = (wr && addr[SMW_RO_BIT]) || (!wr && addr[SMW_WO_BIT]) || !in_range || !bg;
  endfunction

  // ==============================================================
  // Request side (sys_clk)
  assign take = (state_reg == SMW_IDLE) && req_valid;
  assign blocked_now = refused(req.write, req.addr, req_background);
  assign accept = take && !blocked_now;
  // Hold the slot for the full word time even if the link is faster
  assign span_done = (32'(wait_cnt_reg) >= XFER_CYCLES - 1);
  assign finish = (state_reg == SMW_DONE) && span_done;
  assign done_seen = done_sync_reg[2] ^ done_sync_reg[1];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SMW_IDLE: begin
        if (accept) begin
          state_next = SMW_WAIT;
        end
      end
      SMW_WAIT: begin
        if (done_seen) begin
          state_next = SMW_DONE;
        end
      end
      SMW_DONE: begin
        if (span_done) begin
          state_next = SMW_IDLE;
        end
      end
      default: state_next = SMW_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= SMW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Saturates so a stalled link cannot wrap into a late answer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_cnt_reg <= '0;
    end else if (accept) begin
      wait_cnt_reg <= '0;
    end else if (state_reg != SMW_IDLE && wait_cnt_reg != 16'hffff) begin
      wait_cnt_reg <= wait_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      job_write_reg <= 1'b0;
      job_word_reg <= '0;
      job_data_reg <= SMW_WORD_RST;
    end else if (accept) begin
      job_write_reg <= req.write;
      job_word_reg <= word_of(req.addr);
      job_data_reg <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      go_tog_reg <= 1'b0;
    end else if (accept) begin
      go_tog_reg <= ~go_tog_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b1;
    end else if (accept) begin
      req_ready <= 1'b0;
    end else if (finish) begin
      req_ready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (take && blocked_now) || finish;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp <= '0;
    end else if (take && blocked_now) begin
      rsp.rdata <= SMW_WORD_RST;
      rsp.blocked <= 1'b1;
    end else if (finish) begin
      rsp.rdata <= job_write_reg ? SMW_WORD_RST : rd_hold_reg;
      rsp.blocked <= 1'b0;
    end
  end

  // Toggle handshake back from the link; only the last two stages compare
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_sync_reg <= '0;
    end else begin
      done_sync_reg <= {done_sync_reg[1:0], done_tog_reg};
    end
  end

  // Direction map: one bit per word, whole word flips at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dir_out_reg <= '0;
    end else if (accept) begin
      dir_out_reg[word_of(req.addr)] <= req.write;
    end
  end

  // Read data is stable in the link's register once done is seen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_hold_reg <= '0;
    end else if (state_reg == SMW_WAIT && done_seen) begin
      rd_hold_reg <= lk_shift_reg;
    end
  end

  // ==============================================================
  // Link side (link_clk); job fields stay stable while a toggle is pending
  assign go_seen = go_sync_reg[2] ^ go_sync_reg[1];
  assign frame_start = (lstate_reg == SMW_L_IDLE) && go_seen;
  assign ph_low = (lstate_reg == SMW_L_SHIFT) && (div_reg == 2'd0);
  assign ph_high = (lstate_reg == SMW_L_SHIFT) && (div_reg == 2'd2);
  // Sample a cycle after the rise: returned data needs two sync stages
  assign ph_sample = (lstate_reg == SMW_L_SHIFT) && (div_reg == 2'd3);
  assign last_bit = ph_sample && (bit_cnt_reg == 6'd31);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      go_sync_reg <= '0;
    end else begin
      go_sync_reg <= {go_sync_reg[1:0], go_tog_reg};
    end
  end

  // Port data is asynchronous to the link clock
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      din_sync_reg <= '0;
    end else begin
      din_sync_reg <= {din_sync_reg[0], port_din};
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lstate_reg <= SMW_L_IDLE;
    end else begin
      unique case (lstate_reg)
        SMW_L_IDLE: begin
          if (frame_start) begin
            lstate_reg <= SMW_L_SHIFT;
          end
        end
        SMW_L_SHIFT: begin
          if (last_bit) begin
            lstate_reg <= SMW_L_ACK;
          end
        end
        SMW_L_ACK: begin
          lstate_reg <= SMW_L_IDLE;
        end
        default: lstate_reg <= SMW_L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      div_reg <= '0;
    end else if (lstate_reg == SMW_L_SHIFT) begin
      div_reg <= div_reg + 2'd1;
    end else begin
      div_reg <= '0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= '0;
    end else if (frame_start) begin
      bit_cnt_reg <= '0;
    end else if (ph_sample) begin
      bit_cnt_reg <= bit_cnt_reg + 6'd1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lk_shift_reg <= '0;
    end else if (frame_start) begin
      lk_shift_reg <= job_data_reg;
    end else if (ph_sample) begin
      lk_shift_reg <= {din_sync_reg[1], lk_shift_reg[31:1]};
    end
  end

  // Idle high so the board sees no edge between frames
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      port_clk <= 1'b1;
    end else if (ph_low) begin
      port_clk <= 1'b0;
    end else if (ph_high) begin
      port_clk <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      port_sel <= 1'b0;
    end else if (frame_start) begin
      port_sel <= 1'b1;
    end else if (lstate_reg == SMW_L_ACK) begin
      port_sel <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      port_write <= 1'b0;
    end else if (frame_start) begin
      port_write <= job_write_reg;
    end else if (lstate_reg == SMW_L_ACK) begin
      port_write <= 1'b0;
    end
  end

  // Advances after the eighth bit of each byte
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      port_byte_addr <= '0;
    end else if (frame_start) begin
      port_byte_addr <= {job_word_reg, 2'b00};
    end else if (ph_sample && bit_cnt_reg[2:0] == 3'd7) begin
      port_byte_addr <= port_byte_addr + 7'd1;
    end
  end

  // Idle level one, least significant bit leaves first
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      port_dout <= 1'b1;
    end else if (ph_low) begin
      port_dout <= lk_shift_reg[0];
    end else if (lstate_reg == SMW_L_ACK) begin
      port_dout <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      done_tog_reg <= 1'b0;
    end else if (lstate_reg == SMW_L_ACK) begin
      done_tog_reg <= ~done_tog_reg;
    end
  end

endmodule

// ### verification/smw_word_port_chk.sv
// Checker for the serial multiplexed word port
`timescale 1ns/1ns
module smw_chk
  import smw_pkg::*;
#(
  parameter int XFER_CYCLES = SMW_XFER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_background,
  input wire smw_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire smw_rsp_s rsp,
  input wire logic [31:0] dir_out_reg
);
  // ==========
  // Helpers
  logic [4:0] idx_reg;
  logic [15:0] busy_reg;
  always_ff @(posedge sys_clk) idx_reg <= req.addr[6:2];
  always_ff @(posedge sys_clk) busy_reg <= req_ready ? 16'h0000 : busy_reg + 16'h0001;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_ok; req_background && (req.write ? !req.addr[0] : !req.addr[1]); endsequence
  property p_fg; s_take ##0 !req_background |=> rsp_valid && rsp.blocked && $stable(dir_out_reg); endproperty
  a_fg: assert property (p_fg) else $error("foreground request taken");
  property p_wblk; s_take ##0 req.write && req.addr[0] |=> rsp_valid && rsp.blocked && $stable(dir_out_reg); endproperty
  a_wblk: assert property (p_wblk) else $error("write to read-only word not blocked");
  property p_rblk; s_take ##0 !req.write && req.addr[1] |=> rsp_valid && rsp.rdata == 32'h0000_0000; endproperty
  a_rblk: assert property (p_rblk) else $error("read of write-only word not zero");
  property p_wdir; s_take ##0 s_ok ##0 req.write |=> dir_out_reg[idx_reg] && !req_ready; endproperty
  a_wdir: assert property (p_wdir) else $error("write did not make word output");
  property p_rdir; s_take ##0 s_ok ##0 !req.write |=> !dir_out_reg[idx_reg]; endproperty
  a_rdir: assert property (p_rdir) else $error("read did not make word input");
  property p_fin; s_take ##0 s_ok |=> !rsp_valid [*8] ##[1:1000] rsp_valid && !rsp.blocked; endproperty
  a_fin: assert property (p_fin) else $error("transfer did not finish in time");
  property p_dur; rsp_valid && !rsp.blocked |-> busy_reg >= XFER_CYCLES - 1; endproperty
  a_dur: assert property (p_dur) else $error("transfer answered too early");
  property p_rst; $rose(rst_n) |-> req_ready && dir_out_reg == 32'h0000_0000; endproperty
  a_rst: assert property (p_rst) else $error("words not inputs after reset");
endmodule
bind smw_word_port smw_chk #(.XFER_CYCLES(XFER_CYCLES)) i_chk (.*);

// ### verification/smw_board.sv
// Behavioural expansion board model at the far end of the link
`timescale 1ns/1ns
module smw_board (
  input wire logic port_clk,
  input wire logic port_sel,
  input wire logic [6:0] port_byte_addr,
  input wire logic port_dout,
  input wire logic port_write,
  output logic port_din
);
  // ==========
  // Word store
  logic [31:0] mem [32];
  logic [4:0] widx;
  int bidx;
  initial begin
    port_din = 1'b1;
    for (int i = 0; i < 32; i++) mem[i] = 32'hc35a_0000 + i;
  end
  always @(posedge port_sel) bidx = 0;
  // Data leaves on the falling port clock, ahead of the sampling edge
  always @(negedge port_clk) if (port_sel && bidx < 32) begin
    if (bidx == 0) widx = port_byte_addr[6:2];
    port_din = mem[widx][bidx];
  end
  always @(posedge port_clk) if (port_sel) begin
    if (port_write && bidx < 32) mem[widx][bidx] = port_dout;
    bidx++;
  end
  // Released line must not keep a stale level
  always @(negedge port_sel) port_din = ~port_din;
endmodule

// ### verification/serial_muxed_io_word_port_tb.sv
// Self-checking testbench for the serial multiplexed word port
`timescale 1ns/1ns
module serial_muxed_io_word_port_tb;
  import smw_pkg::*;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
  logic req_valid = 1'b0, req_background = 1'b1, req_ready, rsp_valid;
  logic port_clk, port_sel, port_dout, port_write, port_din;
  smw_req_s req = '0;
  smw_rsp_s rsp;
  logic [31:0] dir_out_reg;
  logic [6:0] port_byte_addr;
  int miscompares = 0, num_checks = 0;
  always #50 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;
  smw_word_port #(.XFER_CYCLES(40)) i_dut (.*);
  smw_board i_board (.*);
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [6:0] a, input logic [31:0] d, input logic bg);
    int k;
    k = 0;
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_background = bg;
    req = '{w, a, d};
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 2000) miscompares++;
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk(dir_out_reg, 32'h0000_0000);
    chk(req_ready, 1);
  endtask
  task automatic t_write;
    op(1, 7'h08, 32'h1234_5678, 1);
    chk(rsp.blocked, 0);
    chk(i_board.mem[2], 32'h1234_5678);
    op(1, 7'h7e, 32'hffff_0001, 1);
    chk(dir_out_reg, 32'h8000_0004);
    chk(i_board.mem[31], 32'hffff_0001);
  endtask
  task automatic t_refuse;
    op(1, 7'h11, 32'hdead_beef, 1);
    chk(rsp.blocked, 1);
    chk(i_board.mem[4], 32'hc35a_0004);
    op(0, 7'h7e, 32'h0000_0000, 1);
    chk(rsp.rdata, 32'h0000_0000);
    chk(dir_out_reg, 32'h8000_0004);
    op(1, 7'h0c, 32'h5555_aaaa, 0);
    chk(rsp.blocked, 1);
    chk(i_board.mem[3], 32'hc35a_0003);
  endtask
  task automatic t_read;
    op(0, 7'h15, 32'h0000_0000, 1);
    chk(rsp.rdata, 32'hc35a_0005);
    op(0, 7'h08, 32'h0000_0000, 1);
    chk(dir_out_reg, 32'h8000_0000);
    chk(rsp.rdata, 32'h1234_5678);
  endtask
  initial begin
    #1_000_000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    t_reset();
    t_write();
    t_refuse();
    t_read();
    stop_test();
  end
endmodule
